//--- core/deri_top.sv
/*
 Drive enable and alarm interlock: decides when the power stage may modulate,
 latches alarms and unlocks them from the reset terminal.
 Assumes terminals arrive as raw pin levels; option bits are static settings
 held by the surrounding controller; alarm memory is kept by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module deri_top (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_B,
    // Local terminals, raw pins
    input wire logic [7:0] DIGITAL_INPUTS,
    input wire logic ENABLE_A,
    input wire logic ENABLE_B,
    // Remote terminal boards, raw
    input wire logic [deri_pkg::BOARDS-1:0] BOARD_ACTIVE,
    input wire logic [deri_pkg::BOARDS-1:0] BOARD_ENABLE_TERMINAL,
    input wire logic [deri_pkg::BOARDS-1:0] BOARD_SOFTWARE_PERMIT,
    // Other function inputs, same clock
    input wire logic DISABLE_INPUT,
    input wire logic PID_DISABLE_REQ,
    input wire logic KEYPAD_RESET,
    input wire logic PARAM_WRITE_REQ,
    // Alarm sources, same clock
    input wire logic ALARM_TRIP,
    input wire logic [deri_pkg::ALARM_W-1:0] ALARM_CODE_IN,
    input wire logic ALARM_CAUSE_ACTIVE,
    input wire logic [deri_pkg::ALARM_W-1:0] STORED_ALARM_CODE,
    // Options
    input wire logic [1:0] CONTROL_TYPE,
    input wire logic SAFE_START_OPTION,
    input wire logic RESET_TERMINAL_OFF,
    input wire logic HW_ONLY_PERMIT,
    input wire logic FLUX_WITH_START_ONLY,
    input wire logic PARAM_CHANGE_CONDITION,
    input wire logic MIN_REF_GATE_OPTION,
    input wire logic PID_DISABLE_OPTION,
    input wire logic [deri_pkg::ON_TIMER_W-1:0] ENABLE_ON_DELAY,
    input wire logic [deri_pkg::REF_W-1:0] MIN_REF_THRESHOLD,
    input wire logic [deri_pkg::REF_W-1:0] REFERENCE,
    input wire logic [deri_pkg::RATE_W-1:0] RAMP_RATE,
    // Outputs
    output logic MODULATE,
    output logic ZERO_VOLTAGE,
    output logic RUN,
    output logic FLUXING,
    output logic LOCKED,
    output logic [deri_pkg::ALARM_W-1:0] ALARM_CODE,
    output logic INVERTER_OK,
    output logic CONSISTENCY_ARMED,
    output logic PARAM_WRITE_ALLOWED,
    output logic COMBINED_HW_ENABLE,
    output logic ENABLE_STATUS,
    output logic [deri_pkg::REF_W-1:0] SETPOINT,
    output logic MULTISPEED_SEL0,
    output logic MULTISPEED_SEL1,
    output logic SOURCE_SELECT,
    output logic LOCAL_REMOTE,
    output logic REFERENCE_REVERSAL
);
    localparam int PW = 10 + 3 * deri_pkg::BOARDS;

    logic [PW-1:0] pins_s;
    logic [7:0] din;
    logic ena_a;
    logic ena_b;
    logic [deri_pkg::BOARDS-1:0] brd_act;
    logic [deri_pkg::BOARDS-1:0] brd_en;
    logic [deri_pkg::BOARDS-1:0] brd_sw;

    logic combined_hw_enable;
    logic board_ok;
    logic software_permit;
    logic raw_enable;
    logic [deri_pkg::ON_TIMER_W-1:0] on_cnt;
    logic enable_filt;
    logic hw_and_board;
    logic stop_now;
    logic [1:0] warm;
    logic permit;
    logic start;
    logic reset_term;
    logic reset_term_d;
    logic reset_pulse;
    logic seen_off;
    logic alarm_latched;
    logic vector_mode;
    logic ref_gate;
    logic run_req;
    logic [deri_pkg::DELAY_W-1:0] sd_cnt;
    logic [deri_pkg::REF_W-1:0] ramp_sp;
    deri_pkg::deri_state_t state;
    deri_pkg::deri_state_t next_state;

    deri_sync #(
        .W(PW)
    ) u_sync (
        .clk(CLOCK),
        .rst_b(RST_B),
        .d({BOARD_SOFTWARE_PERMIT, BOARD_ENABLE_TERMINAL, BOARD_ACTIVE,
            ENABLE_B, ENABLE_A, DIGITAL_INPUTS}),
        .q(pins_s)
    );

    always_comb
    begin
        din = pins_s[7:0];
        ena_a = pins_s[8];
        ena_b = pins_s[9];
        brd_act = pins_s[10 +: deri_pkg::BOARDS];
        brd_en = pins_s[10 + deri_pkg::BOARDS +: deri_pkg::BOARDS];
        brd_sw = pins_s[10 + 2 * deri_pkg::BOARDS +: deri_pkg::BOARDS];
    end

    // =========================================
    // Enable path
    always_comb
    begin
        combined_hw_enable = ena_a & ena_b & din[deri_pkg::IN_ENABLE];
        board_ok = HW_ONLY_PERMIT | (&(brd_en | ~brd_act));
        software_permit = &(brd_sw | ~brd_act);
        hw_and_board = combined_hw_enable & board_ok;
        // Contact, board or trip loss skips the controlled shutdown
        stop_now = ~(ena_a & ena_b) | ~board_ok | ALARM_TRIP;
        raw_enable = hw_and_board & software_permit & ~DISABLE_INPUT;
        start = din[deri_pkg::IN_START];
        vector_mode = (CONTROL_TYPE == deri_pkg::CTRL_VECTOR_TORQUE)
            || (CONTROL_TYPE == deri_pkg::CTRL_FIELD_ORIENTED);
        // Minimum-reference gate: always on in scalar control
        ref_gate = ((CONTROL_TYPE == deri_pkg::CTRL_SCALAR_VF) || MIN_REF_GATE_OPTION)
            && start && (REFERENCE < MIN_REF_THRESHOLD);
        permit = enable_filt & ~alarm_latched & seen_off & ~ref_gate
            & ~(PID_DISABLE_OPTION & PID_DISABLE_REQ);
        run_req = permit & start;
    end

    // On-delay only; a falling raw enable clears the filter at once
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            on_cnt <= '0;
            enable_filt <= 1'b0;
        end
        else if (!raw_enable)
        begin
            on_cnt <= '0;
            enable_filt <= 1'b0;
        end
        else if (on_cnt >= ENABLE_ON_DELAY)
            enable_filt <= 1'b1;
        else
            on_cnt <= on_cnt + 1'b1;
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            warm <= '0;
        else
            warm <= {warm[0], 1'b1};
    end

    // Safe start: enable must be seen low after power-on and after an alarm
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            seen_off <= 1'b0;
        // Synchroniser zeros after reset must not count as enable seen off
        else if (!SAFE_START_OPTION || (warm[1] && !raw_enable))
            seen_off <= 1'b1;
        else if (ALARM_TRIP)
            seen_off <= 1'b0;
    end

    // =========================================
    // Alarm latch and reset terminal
    always_comb
    begin
        reset_term = din[deri_pkg::IN_RESET] & ~RESET_TERMINAL_OFF;
        reset_pulse = (reset_term & ~reset_term_d) | KEYPAD_RESET;
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            reset_term_d <= 1'b0;
        else
            reset_term_d <= reset_term;
    end

    // Stored code is reloaded one cycle after release; a trip beats a reset
    logic restored;
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            restored <= 1'b0;
            alarm_latched <= 1'b1;
            ALARM_CODE <= deri_pkg::ALARM_NONE;
        end
        else if (!restored)
        begin
            restored <= 1'b1;
            alarm_latched <= (STORED_ALARM_CODE != deri_pkg::ALARM_NONE);
            ALARM_CODE <= STORED_ALARM_CODE;
        end
        else if (ALARM_TRIP)
        begin
            alarm_latched <= 1'b1;
            ALARM_CODE <= ALARM_CODE_IN;
        end
        else if (reset_pulse && !ALARM_CAUSE_ACTIVE)
        begin
            alarm_latched <= 1'b0;
            ALARM_CODE <= deri_pkg::ALARM_NONE;
        end
    end

    // =========================================
    // Drive state
    always_comb
    begin
        next_state = state;
        case (state)
            deri_pkg::ST_LOCKED:
                if (permit && !stop_now)
                    next_state = deri_pkg::ST_READY;
            deri_pkg::ST_READY:
                if (!permit || stop_now)
                    next_state = deri_pkg::ST_LOCKED;
                else if (run_req)
                    next_state = deri_pkg::ST_RUN;
            deri_pkg::ST_RUN:
                // Board or hardware loss and trips stop at once
                if (stop_now || alarm_latched)
                    next_state = deri_pkg::ST_LOCKED;
                else if (!enable_filt)
                    next_state = deri_pkg::ST_SHUTDOWN;
                else if (!permit)
                    next_state = deri_pkg::ST_LOCKED;
                else if (!start)
                    next_state = deri_pkg::ST_READY;
            deri_pkg::ST_SHUTDOWN:
                if (stop_now
                    || sd_cnt >= deri_pkg::DELAY_W'(deri_pkg::SHUTDOWN_CYCLES - 1))
                    next_state = deri_pkg::ST_LOCKED;
            default:
                next_state = deri_pkg::ST_LOCKED;
        endcase
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            state <= deri_pkg::ST_LOCKED;
        else
            state <= next_state;
    end

    // Counts from the cycle the filtered enable fell, not from any timer
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            sd_cnt <= '0;
        else if (state != deri_pkg::ST_SHUTDOWN)
            sd_cnt <= '0;
        else
            sd_cnt <= sd_cnt + 1'b1;
    end

    deri_ramp u_ramp (
        .clk(CLOCK),
        .rst_b(RST_B),
        .run(next_state == deri_pkg::ST_RUN),
        .target(REFERENCE),
        .rate(RAMP_RATE),
        .setpoint(ramp_sp)
    );

    // =========================================
    // Registered outputs
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            MODULATE <= 1'b0;
            ZERO_VOLTAGE <= 1'b1;
            RUN <= 1'b0;
            FLUXING <= 1'b0;
            LOCKED <= 1'b1;
            INVERTER_OK <= 1'b0;
            CONSISTENCY_ARMED <= 1'b0;
            PARAM_WRITE_ALLOWED <= 1'b0;
            COMBINED_HW_ENABLE <= 1'b0;
            ENABLE_STATUS <= 1'b0;
            SETPOINT <= '0;
        end
        else
        begin
            MODULATE <= (next_state == deri_pkg::ST_RUN)
                || (next_state == deri_pkg::ST_SHUTDOWN)
                || ((next_state == deri_pkg::ST_READY) && vector_mode
                    && (!FLUX_WITH_START_ONLY || start));
            ZERO_VOLTAGE <= (next_state == deri_pkg::ST_LOCKED)
                || ((next_state == deri_pkg::ST_READY)
                    && !(vector_mode && (!FLUX_WITH_START_ONLY || start)));
            RUN <= (next_state == deri_pkg::ST_RUN);
            FLUXING <= (next_state == deri_pkg::ST_READY) && vector_mode
                && (!FLUX_WITH_START_ONLY || start);
            LOCKED <= alarm_latched || ALARM_TRIP;
            INVERTER_OK <= !alarm_latched && !ALARM_TRIP;
            CONSISTENCY_ARMED <= enable_filt;
            PARAM_WRITE_ALLOWED <= PARAM_WRITE_REQ && (!enable_filt
                || (PARAM_CHANGE_CONDITION && next_state != deri_pkg::ST_RUN
                    && next_state != deri_pkg::ST_SHUTDOWN));
            COMBINED_HW_ENABLE <= combined_hw_enable;
            ENABLE_STATUS <= enable_filt;
            SETPOINT <= ramp_sp;
        end
    end

    // Factory-mapped pass-through functions
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            MULTISPEED_SEL0 <= 1'b0;
            MULTISPEED_SEL1 <= 1'b0;
            SOURCE_SELECT <= 1'b0;
            LOCAL_REMOTE <= 1'b0;
            REFERENCE_REVERSAL <= 1'b0;
        end
        else
        begin
            MULTISPEED_SEL0 <= din[deri_pkg::IN_MSPD0];
            MULTISPEED_SEL1 <= din[deri_pkg::IN_MSPD1];
            SOURCE_SELECT <= din[deri_pkg::IN_SRC_SEL];
            LOCAL_REMOTE <= din[deri_pkg::IN_LOC_REM];
            REFERENCE_REVERSAL <= din[deri_pkg::IN_REV];
        end
    end
endmodule
`default_nettype wire

//--- core/deri_pkg.sv
/*
 Constants and types shared by the drive enable and alarm interlock.
 Assumes a single 100 MHz control clock and an asynchronous active-low reset.
*/
// How it works
// - Enable off forces zero voltage, coasting
// - Controlled shutdown delayed from enable fall
// - Disable input and software permit gate enable
// - Low reference with start blocks operation
// - PID regulator may disable the drive
// - Board enable loss disables output instantly
// - Either hardware enable opening disables output
// - Trip disables, locks, latches alarm code
// - Enable timer delays only rising edge
// - Enable arms configuration consistency alarms
// - Parameter writes locked while enabled, option
// - Vector controls flux while enabled, option
// - Safe start refuses enable present at power-on
// - Reset fixed to input three, removable
// - Reset unlocks only when cause cleared
// - Safe start needs enable re-cycle after alarm
// - Latched alarm restored at power-on, locked
// - Factory mapping of the eight inputs
// - Combined enable needs both hardware inputs
// - Board enables required unless hardware-only option
// - Start and enable give run and ramp
package deri_pkg;

    localparam int CLK_MHZ = 100;
    // Controlled shutdown delay after enable falls, model-dependent
    localparam int SHUTDOWN_DELAY_US = 20;
    localparam int SHUTDOWN_CYCLES = SHUTDOWN_DELAY_US * CLK_MHZ;
    localparam int DELAY_W = 12;
    // Rising-edge filter on the enable terminal
    localparam int ON_TIMER_W = 16;

    localparam int BOARDS = 2;
    localparam int ALARM_W = 8;
    localparam int REF_W = 16;
    localparam int RATE_W = 16;

    localparam logic [ALARM_W-1:0] ALARM_NONE = 8'h00;

    // Factory input positions, zero based
    localparam int IN_START = 0;
    localparam int IN_ENABLE = 1;
    localparam int IN_RESET = 2;
    localparam int IN_MSPD0 = 3;
    localparam int IN_MSPD1 = 4;
    localparam int IN_SRC_SEL = 5;
    localparam int IN_LOC_REM = 6;
    localparam int IN_REV = 7;

    typedef enum logic [1:0] {
        CTRL_SCALAR_VF = 2'h0,
        CTRL_VECTOR_TORQUE = 2'h1,
        CTRL_FIELD_ORIENTED = 2'h2
    } deri_ctrl_t;

    typedef enum logic [1:0] {
        ST_LOCKED = 2'h0,
        ST_READY = 2'h1,
        ST_RUN = 2'h3,
        ST_SHUTDOWN = 2'h2
    } deri_state_t;

endpackage

//--- core/deri_sync.sv
/*
 Two-flop synchroniser for a bundle of pin levels.
 Assumes inputs are asynchronous levels; output lags two clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module deri_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule
`default_nettype wire

//--- core/deri_ramp.sv
/*
 Setpoint ramp toward a target at a fixed step per clock.
 Assumes target and rate come from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module deri_ramp (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Control
    input wire logic run,
    input wire logic [deri_pkg::REF_W-1:0] target,
    input wire logic [deri_pkg::RATE_W-1:0] rate,
    // Result
    output logic [deri_pkg::REF_W-1:0] setpoint
);
    logic [deri_pkg::REF_W-1:0] goal;
    logic [deri_pkg::REF_W:0] up;
    logic [deri_pkg::REF_W-1:0] gap;

    always_comb
    begin
        goal = run ? target : '0;
        up = {1'b0, setpoint} + {1'b0, rate};
        gap = (goal > setpoint) ? goal - setpoint : setpoint - goal;
    end

    // A step never overshoots: the last step lands exactly on the goal
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            setpoint <= '0;
        else if (gap <= rate)
            setpoint <= goal;
        else if (goal > setpoint)
            setpoint <= up[deri_pkg::REF_W-1:0];
        else
            setpoint <= setpoint - rate;
    end
endmodule
`default_nettype wire

//--- tb/deri_wiring.sv
/*
 Model of the control wiring in front of the interlock: hardware enable
 contacts and the eight local input pins. Assumes the bench changes its
 commands at the falling clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module deri_wiring (
    // Commands from the bench
    input wire logic close_a,
    input wire logic close_b,
    input wire logic term_en,
    input wire logic start,
    input wire logic clr,
    input wire logic [4:0] aux,
    // Pins towards the drive
    output logic ENABLE_A,
    output logic ENABLE_B,
    output logic [7:0] DIGITAL_INPUTS
);
    // Safe stop is taken by opening a contact, never by a soft disable
    assign ENABLE_A = close_a;
    assign ENABLE_B = close_b;
    // Clear is only ever a short pulse from the bench
    assign DIGITAL_INPUTS = {aux, clr, term_en, start};
endmodule
`default_nettype wire

//--- tb/deri_props.sv
/*
 Concurrent checks on the interlock ports.
 Assumes pin inputs lag three clocks to outputs, same-clock inputs one.
*/
`timescale 1ns/1ps
`default_nettype none
module deri_props (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_B,
    // Watched inputs
    input wire logic [7:0] DIGITAL_INPUTS,
    input wire logic ENABLE_A,
    input wire logic ENABLE_B,
    input wire logic [deri_pkg::BOARDS-1:0] BOARD_ACTIVE,
    input wire logic [deri_pkg::BOARDS-1:0] BOARD_ENABLE_TERMINAL,
    input wire logic HW_ONLY_PERMIT,
    input wire logic PID_DISABLE_REQ,
    input wire logic PID_DISABLE_OPTION,
    input wire logic ALARM_TRIP,
    input wire logic [deri_pkg::ALARM_W-1:0] ALARM_CODE_IN,
    input wire logic ALARM_CAUSE_ACTIVE,
    input wire logic PARAM_CHANGE_CONDITION,
    // Watched outputs
    input wire logic MODULATE,
    input wire logic ZERO_VOLTAGE,
    input wire logic RUN,
    input wire logic LOCKED,
    input wire logic [deri_pkg::ALARM_W-1:0] ALARM_CODE,
    input wire logic CONSISTENCY_ARMED,
    input wire logic PARAM_WRITE_ALLOWED,
    input wire logic COMBINED_HW_ENABLE,
    input wire logic ENABLE_STATUS
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_B);

    // ========================================
    // Enable path
    a_zero_when_idle: assert property (!MODULATE |-> ZERO_VOLTAGE)
        else $error("output voltage not zero while not modulating");
    a_hw_open_stops: assert property ((!ENABLE_A || !ENABLE_B)[*3] |=> !MODULATE)
        else $error("modulating with a hardware enable open");
    a_combined_needs_all: assert property
        ((!ENABLE_A || !ENABLE_B || !DIGITAL_INPUTS[1])[*3] |=> !COMBINED_HW_ENABLE)
        else $error("combined enable high with an input open");
    a_board_loss_stops: assert property
        ((BOARD_ACTIVE[0] && !BOARD_ENABLE_TERMINAL[0] && !HW_ONLY_PERMIT)[*3]
        |=> !MODULATE)
        else $error("modulating after board enable loss");
    a_pid_blocks_run: assert property
        ((PID_DISABLE_OPTION && PID_DISABLE_REQ)[*2] |=> !RUN)
        else $error("running while regulator disables");
    a_armed_needs_enable: assert property (!ENABLE_STATUS[*2] |-> !CONSISTENCY_ARMED)
        else $error("consistency alarms armed without enable");
    a_param_lock: assert property
        (ENABLE_STATUS && $past(ENABLE_STATUS) && !PARAM_CHANGE_CONDITION
        |-> !PARAM_WRITE_ALLOWED)
        else $error("parameter write allowed while enabled");

    // ========================================
    // Alarms
    a_trip_latches: assert property
        (ALARM_TRIP && ALARM_CODE == deri_pkg::ALARM_NONE
        |=> ALARM_CODE == $past(ALARM_CODE_IN) && LOCKED && !MODULATE)
        else $error("trip not latched and locked");
    a_alarm_locks: assert property
        (ALARM_CODE != deri_pkg::ALARM_NONE |-> LOCKED && !MODULATE)
        else $error("alarm latched but drive not locked");
    a_cause_keeps_alarm: assert property
        (ALARM_CAUSE_ACTIVE && ALARM_CODE != deri_pkg::ALARM_NONE && !ALARM_TRIP
        |=> ALARM_CODE == $past(ALARM_CODE))
        else $error("alarm cleared while cause active");
endmodule

bind deri_top deri_props u_deri_props (.CLOCK, .RST_B, .DIGITAL_INPUTS, .ENABLE_A,
    .ENABLE_B, .BOARD_ACTIVE, .BOARD_ENABLE_TERMINAL, .HW_ONLY_PERMIT, .PID_DISABLE_REQ,
    .PID_DISABLE_OPTION, .ALARM_TRIP, .ALARM_CODE_IN, .ALARM_CAUSE_ACTIVE,
    .PARAM_CHANGE_CONDITION, .MODULATE, .ZERO_VOLTAGE, .RUN, .LOCKED, .ALARM_CODE,
    .CONSISTENCY_ARMED, .PARAM_WRITE_ALLOWED, .COMBINED_HW_ENABLE, .ENABLE_STATUS);
`default_nettype wire

//--- tb/deri_top_tb.sv
/*
 Self-checking bench for the drive enable and alarm interlock.
 Assumes the wiring model drives the local pins and the bench the rest.
*/
`timescale 1ns/1ps
`default_nettype none
module deri_top_tb;
    // Bench signals carry the port names so the instance connects by name
    logic CLOCK = 1'b0;
    logic RST_B = 1'b0;
    logic [7:0] DIGITAL_INPUTS;
    logic ENABLE_A, ENABLE_B;
    logic [1:0] BOARD_ACTIVE, BOARD_ENABLE_TERMINAL, BOARD_SOFTWARE_PERMIT;
    logic DISABLE_INPUT, PID_DISABLE_REQ, KEYPAD_RESET, PARAM_WRITE_REQ;
    logic ALARM_TRIP, ALARM_CAUSE_ACTIVE;
    logic [7:0] ALARM_CODE_IN, STORED_ALARM_CODE, ALARM_CODE;
    logic [1:0] CONTROL_TYPE;
    logic SAFE_START_OPTION, RESET_TERMINAL_OFF, HW_ONLY_PERMIT, FLUX_WITH_START_ONLY;
    logic PARAM_CHANGE_CONDITION, MIN_REF_GATE_OPTION, PID_DISABLE_OPTION;
    logic [15:0] ENABLE_ON_DELAY, MIN_REF_THRESHOLD, REFERENCE, RAMP_RATE, SETPOINT;
    logic MODULATE, ZERO_VOLTAGE, RUN, FLUXING, LOCKED, INVERTER_OK, CONSISTENCY_ARMED;
    logic PARAM_WRITE_ALLOWED, COMBINED_HW_ENABLE, ENABLE_STATUS, MULTISPEED_SEL0;
    logic MULTISPEED_SEL1, SOURCE_SELECT, LOCAL_REMOTE, REFERENCE_REVERSAL;
    logic close_a, close_b, term_en, start, clr;
    logic [4:0] aux;
    int n_mismatch = 0;
    int compares = 0;

    always #5 CLOCK = ~CLOCK;

    deri_top u_deri_top (.*);
    deri_wiring u_deri_wiring (.close_a(close_a), .close_b(close_b), .term_en(term_en),
        .start(start), .clr(clr), .aux(aux), .ENABLE_A(ENABLE_A), .ENABLE_B(ENABLE_B),
        .DIGITAL_INPUTS(DIGITAL_INPUTS));

    // ========================================
    // Helpers
    task automatic cyc(input int n);
        repeat (n) @(negedge CLOCK);
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Clear pulse outlasts the pin synchroniser, then lets it settle
    task automatic pulse_clear();
        clr = 1'b1;
        cyc(3);
        clr = 1'b0;
        cyc(5);
    endtask

    // Opening a contact for a while lets safe start see enable off
    task automatic recycle_b();
        close_b = 1'b0;
        cyc(10);
        close_b = 1'b1;
        cyc(40);
    endtask

    task automatic end_of_test();
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ========================================
    // Sequence
    initial
    begin
        {close_a, close_b, term_en, start, clr, aux} = {4'hE, 1'h0, 5'h00};
        {BOARD_ACTIVE, BOARD_ENABLE_TERMINAL, BOARD_SOFTWARE_PERMIT} = 6'h0F;
        {DISABLE_INPUT, PID_DISABLE_REQ, KEYPAD_RESET, PARAM_WRITE_REQ} = 4'h1;
        {ALARM_TRIP, ALARM_CAUSE_ACTIVE} = 2'h1;
        ALARM_CODE_IN = 8'h15;
        STORED_ALARM_CODE = 8'h2A;
        CONTROL_TYPE = 2'h1;
        {SAFE_START_OPTION, RESET_TERMINAL_OFF, HW_ONLY_PERMIT} = 3'h4;
        {FLUX_WITH_START_ONLY, PARAM_CHANGE_CONDITION} = 2'h0;
        {MIN_REF_GATE_OPTION, PID_DISABLE_OPTION} = 2'h1;
        ENABLE_ON_DELAY = 16'h0014;
        MIN_REF_THRESHOLD = 16'h0100;
        REFERENCE = 16'h0400;
        RAMP_RATE = 16'h0040;
        cyc(4);
        RST_B = 1'b1;
        cyc(40);
        chk(ALARM_CODE, 16'h002A);
        chk(LOCKED, 16'h0001);
        pulse_clear();
        chk(ALARM_CODE, 16'h002A);
        ALARM_CAUSE_ACTIVE = 1'b0;
        pulse_clear();
        chk(ALARM_CODE, 16'h0000);
        chk(INVERTER_OK, 16'h0001);
        chk(MODULATE, 16'h0000);
        recycle_b();
        chk(MODULATE, 16'h0001);
        chk(CONSISTENCY_ARMED, 16'h0001);
        chk(PARAM_WRITE_ALLOWED, 16'h0000);
        chk(FLUXING, 16'h0001);
        PARAM_CHANGE_CONDITION = 1'b1;
        cyc(3);
        chk(PARAM_WRITE_ALLOWED, 16'h0001);
        close_b = 1'b0;
        cyc(10);
        chk(ENABLE_STATUS, 16'h0000);
        close_b = 1'b1;
        cyc(15);
        chk(ENABLE_STATUS, 16'h0000);
        chk(COMBINED_HW_ENABLE, 16'h0001);
        cyc(20);
        chk(ENABLE_STATUS, 16'h0001);
        start = 1'b1;
        cyc(60);
        chk(RUN, 16'h0001);
        chk(SETPOINT, 16'h0400);
        chk(PARAM_WRITE_ALLOWED, 16'h0000);
        PID_DISABLE_REQ = 1'b1;
        cyc(3);
        chk(RUN, 16'h0000);
        PID_DISABLE_REQ = 1'b0;
        term_en = 1'b0;
        cyc(200);
        chk(MODULATE, 16'h0001);
        cyc(1900);
        chk(MODULATE, 16'h0000);
        chk(ZERO_VOLTAGE, 16'h0001);
        term_en = 1'b1;
        cyc(40);
        chk(MODULATE, 16'h0001);
        close_a = 1'b0;
        cyc(5);
        chk(MODULATE, 16'h0000);
        chk(COMBINED_HW_ENABLE, 16'h0000);
        close_a = 1'b1;
        BOARD_ACTIVE = 2'h1;
        cyc(40);
        chk(MODULATE, 16'h0001);
        BOARD_ENABLE_TERMINAL = 2'h2;
        cyc(5);
        chk(MODULATE, 16'h0000);
        HW_ONLY_PERMIT = 1'b1;
        cyc(40);
        chk(MODULATE, 16'h0001);
        BOARD_SOFTWARE_PERMIT = 2'h2;
        cyc(5);
        chk(RUN, 16'h0000);
        BOARD_SOFTWARE_PERMIT = 2'h3;
        DISABLE_INPUT = 1'b1;
        cyc(5);
        chk(ENABLE_STATUS, 16'h0000);
        DISABLE_INPUT = 1'b0;
        cyc(40);
        chk(ENABLE_STATUS, 16'h0001);
        {ALARM_TRIP, ALARM_CAUSE_ACTIVE} = 2'h3;
        cyc(1);
        ALARM_TRIP = 1'b0;
        cyc(2);
        chk(ALARM_CODE, 16'h0015);
        chk(MODULATE, 16'h0000);
        {ALARM_CAUSE_ACTIVE, RESET_TERMINAL_OFF} = 2'h1;
        pulse_clear();
        chk(ALARM_CODE, 16'h0015);
        KEYPAD_RESET = 1'b1;
        cyc(1);
        KEYPAD_RESET = 1'b0;
        cyc(40);
        chk(ALARM_CODE, 16'h0000);
        chk(MODULATE, 16'h0000);
        recycle_b();
        chk(MODULATE, 16'h0001);
        {start, FLUX_WITH_START_ONLY} = 2'h1;
        cyc(5);
        chk(FLUXING, 16'h0000);
        {start, CONTROL_TYPE, REFERENCE} = {1'h1, 2'h0, 16'h0080};
        cyc(10);
        chk(RUN, 16'h0000);
        REFERENCE = 16'h0200;
        cyc(5);
        chk(RUN, 16'h0001);
        {CONTROL_TYPE, MIN_REF_GATE_OPTION, REFERENCE} = {2'h2, 1'h1, 16'h0080};
        cyc(5);
        chk(RUN, 16'h0000);
        for (int i = 0; i < 5; i++)
        begin
            aux = 5'h01 << i;
            cyc(4);
            chk({REFERENCE_REVERSAL, LOCAL_REMOTE, SOURCE_SELECT, MULTISPEED_SEL1,
                MULTISPEED_SEL0}, {11'h000, aux});
        end
        end_of_test();
    end

    // Whole sequence is about 2650 cycles; allow 6000
    initial
    begin
        #60us;
        n_mismatch++;
        end_of_test();
    end
endmodule
`default_nettype wire
